// ===== logic/cdac_pkg.sv
// constants for the current dac update control block
package cdac_pkg;
	// register offsets on the local port
	localparam logic [7:0] ADDR_DATA_LOW = 8'h96;
	localparam logic [7:0] ADDR_DATA_HIGH = 8'h97;
	localparam logic [7:0] ADDR_CONTROL = 8'hB9;
	// control field positions
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_SRC_MSB = 6;
	localparam int CTL_SRC_LSB = 4;
	localparam int CTL_FS_MSB = 1;
	localparam int CTL_FS_LSB = 0;
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h72;
	localparam logic [7:0] DATA_HIGH_RESET = 8'h00;
	localparam logic [7:0] DATA_LOW_RESET = 8'h00;
	// writable bits
	localparam logic [7:0] CONTROL_WMASK = 8'hF3;
	localparam logic [7:0] DATA_LOW_WMASK = 8'hC0;
	localparam int CODE_W = 10;
	// update source selection
	typedef enum logic [2:0] {
		CDAC_SRC_T0 = 3'b000,
		CDAC_SRC_T1 = 3'b001,
		CDAC_SRC_T2 = 3'b010,
		CDAC_SRC_T3 = 3'b011,
		CDAC_SRC_RISE = 3'b100,
		CDAC_SRC_FALL = 3'b101,
		CDAC_SRC_BOTH = 3'b110,
		CDAC_SRC_WRITE = 3'b111
	} cdac_src_e;
	// full-scale current codes
	localparam logic [1:0] FS_HALF_MA = 2'b00;
	localparam logic [1:0] FS_ONE_MA = 2'b01;
	localparam logic [1:0] FS_TWO_MA = 2'b10;
endpackage

// ===== logic/cdac_strobe_edge.sv
// synchroniser and edge detector for the external convert strobe
module cdac_strobe_edge (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// strobe pin
	input wire logic i_strobe,
	// edge pulses
	output logic o_rise,
	output logic o_fall
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// two-flop sync, then one flop of history for edges
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= i_strobe;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign o_rise = sync_q & ~last_q; // RULE_17
	assign o_fall = ~sync_q & last_q; // RULE_17
endmodule // cdac_strobe_edge

// ===== logic/cdac_ctrl.sv
// register file and update scheduling for the 10-bit current dac
//
// Contract
// RULE_01: ten-bit converter, three full-scale currents
// RULE_02: disabled converter leaves pin as gpio
// RULE_03: enabled converter takes pin, drops drivers
// RULE_04: bias generator requested while converter enabled
// RULE_05: software sets port0 skip mask bit one
// RULE_06: source 111 updates on high-byte write
// RULE_07: low-byte write held until high write
// RULE_08: software writes low byte then high
// RULE_09: eight-bit use: low byte set once
// RULE_10: sources 000-011 update on timer overflow
// RULE_11: sources 100-110 update on strobe edges
// RULE_12: word left-justified across high, low bytes
// RULE_13: current equals code over 1024 times scale
// RULE_14: scale field 1x two, 01 one mA
// RULE_15: reset full scale is two mA
// RULE_16: scale field 00 gives half mA
// RULE_17: strobe synchronised, one pulse per edge
//
// Added by the designer: the register addresses and the address-and-strobe port.
module cdac_ctrl #(
	parameter int CODE_W = cdac_pkg::CODE_W
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// update sources
	input wire logic [3:0] i_timer_ovf,
	input wire logic i_convert_strobe,
	// analog side
	output logic [CODE_W-1:0] o_code,
	output logic [1:0] o_full_scale_select,
	output logic o_converter_enable,
	output logic o_bias_request,
	output logic o_pin_takeover,
	output logic o_update_pulse
);
	logic [7:0] control_q;
	logic [7:0] data_high_q;
	logic [7:0] data_low_q;
	logic [CODE_W-1:0] code_q;
	logic en_q;
	logic [1:0] fs_q;
	logic upd_q;
	logic [7:0] rdata_q;
	logic wr_ctl;
	logic wr_high;
	logic wr_low;
	logic strobe_rise;
	logic strobe_fall;
	logic update_now;
	cdac_pkg::cdac_src_e src;

	// address compare used by both the write and the read path
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	assign wr_ctl = i_wr & hit(i_addr, cdac_pkg::ADDR_CONTROL);
	assign wr_high = i_wr & hit(i_addr, cdac_pkg::ADDR_DATA_HIGH);
	assign wr_low = i_wr & hit(i_addr, cdac_pkg::ADDR_DATA_LOW);
	assign src = cdac_pkg::cdac_src_e'(
		control_q[cdac_pkg::CTL_SRC_MSB:cdac_pkg::CTL_SRC_LSB]);

	cdac_strobe_edge u_strobe (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_strobe(i_convert_strobe),
		.o_rise(strobe_rise),
		.o_fall(strobe_fall)
	);

	// pick the qualifying event for the selected source
	always_comb begin
		case (src)
			cdac_pkg::CDAC_SRC_T0: update_now = i_timer_ovf[0]; // RULE_10
			cdac_pkg::CDAC_SRC_T1: update_now = i_timer_ovf[1]; // RULE_10
			cdac_pkg::CDAC_SRC_T2: update_now = i_timer_ovf[2]; // RULE_10
			cdac_pkg::CDAC_SRC_T3: update_now = i_timer_ovf[3]; // RULE_10
			cdac_pkg::CDAC_SRC_RISE: update_now = strobe_rise; // RULE_11
			cdac_pkg::CDAC_SRC_FALL: update_now = strobe_fall; // RULE_11
			cdac_pkg::CDAC_SRC_BOTH: begin
				update_now = strobe_rise | strobe_fall; // RULE_11
			end
			cdac_pkg::CDAC_SRC_WRITE: update_now = wr_high; // RULE_06
			default: update_now = 1'b0;
		endcase
	end

	// control register; unused bits 3:2 stay zero
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			control_q <= cdac_pkg::CONTROL_RESET; // RULE_15
		end else if (wr_ctl) begin
			control_q <= i_wdata & cdac_pkg::CONTROL_WMASK;
		end
	end

	// data holding bytes; only a high-byte write in mode 111 reaches the latch directly
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			data_high_q <= cdac_pkg::DATA_HIGH_RESET;
			data_low_q <= cdac_pkg::DATA_LOW_RESET;
		end else begin
			if (wr_high) begin
				data_high_q <= i_wdata;
			end
			if (wr_low) begin
				data_low_q <= i_wdata & cdac_pkg::DATA_LOW_WMASK; // RULE_07
			end
		end
	end

	// input latch: on a high-byte write in mode 111 the new byte is used
	// directly, so the word reflects the write that triggered it
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			code_q <= '0;
		end else if (update_now) begin
			if (src == cdac_pkg::CDAC_SRC_WRITE) begin
				code_q <= {i_wdata, data_low_q[7:6]}; // RULE_06 RULE_12
			end else begin
				code_q <= {data_high_q, data_low_q[7:6]}; // RULE_12
			end
		end
	end

	// analog controls registered so every output comes from a flop;
	// the current is code/1024 of the scale chosen here
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			en_q <= 1'b0;
			fs_q <= cdac_pkg::FS_TWO_MA; // RULE_15
			upd_q <= 1'b0;
		end else begin
			en_q <= control_q[cdac_pkg::CTL_ENABLE_BIT]; // RULE_02 RULE_03
			fs_q <= control_q[cdac_pkg::CTL_FS_MSB:cdac_pkg::CTL_FS_LSB];
			upd_q <= update_now;
		end
	end

	// read data valid the cycle after the strobe, zero otherwise
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			rdata_q <= 8'h00;
		end else if (i_rd) begin
			if (hit(i_addr, cdac_pkg::ADDR_CONTROL)) begin
				rdata_q <= control_q;
			end else if (hit(i_addr, cdac_pkg::ADDR_DATA_HIGH)) begin
				rdata_q <= data_high_q;
			end else if (hit(i_addr, cdac_pkg::ADDR_DATA_LOW)) begin
				rdata_q <= data_low_q;
			end else begin
				rdata_q <= 8'h00;
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign o_rdata = rdata_q;
	assign o_code = code_q; // RULE_01 RULE_13
	assign o_full_scale_select = fs_q; // RULE_14 RULE_16
	assign o_converter_enable = en_q;
	assign o_bias_request = en_q; // RULE_04
	assign o_pin_takeover = en_q; // RULE_03
	assign o_update_pulse = upd_q;

	// a high-byte write in on-demand mode lands in the latch next cycle
	a_demand_update: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_high && src == cdac_pkg::CDAC_SRC_WRITE
		|=> code_q[CODE_W-1:2] == $past(i_wdata)) // RULE_06
		else $error("high write did not update code");

	// a low-byte write alone never moves the code
	a_low_held: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_low && !update_now |=> $stable(code_q)) // RULE_07
		else $error("low write changed code");

	// timer overflow copies the held word
	a_timer_copy: assert property (@(posedge i_clk) disable iff (!i_nrst)
		src == cdac_pkg::CDAC_SRC_T2 && i_timer_ovf[2]
		|=> code_q == {$past(data_high_q), $past(data_low_q[7:6])}) // RULE_10
		else $error("timer 2 overflow missed");

	// no event, no change
	a_code_stable: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!update_now |=> $stable(code_q)) // RULE_11
		else $error("code changed without event");

	// rising strobe in mode 100 gives exactly one pulse
	a_rise_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		strobe_rise && src == cdac_pkg::CDAC_SRC_RISE
		|=> o_update_pulse ##1 !o_update_pulse) // RULE_17
		else $error("strobe rise pulse wrong");

	// falling edge mode ignores rises
	a_fall_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
		src == cdac_pkg::CDAC_SRC_FALL && strobe_rise |-> !update_now) // RULE_11
		else $error("rise accepted in fall mode");

	// enable drives bias and pin takeover together
	a_bias_enable: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_bias_request == o_converter_enable
		&& o_pin_takeover == o_converter_enable) // RULE_04
		else $error("bias or pin mismatch");

	// enable follows the control bit one cycle later
	a_enable_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_ctl ##1 1'b1 |=> o_converter_enable == $past(i_wdata[7], 2)) // RULE_03
		else $error("enable did not follow write");

	// low byte keeps only its top two bits
	a_low_mask: assert property (@(posedge i_clk) disable iff (!i_nrst)
		data_low_q[5:0] == 6'h00 && control_q[3:2] == 2'b00) // RULE_12
		else $error("unused bits set");

	// scale follows the field one cycle later
	a_scale_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_full_scale_select == $past(control_q[1:0])) // RULE_14
		else $error("scale field mismatch");

	// half-scale code reaches the output
	a_scale_half: assert property (@(posedge i_clk) disable iff (!i_nrst)
		control_q[1:0] == cdac_pkg::FS_HALF_MA
		|=> o_full_scale_select == cdac_pkg::FS_HALF_MA) // RULE_16
		else $error("half scale not selected");

	// read data returns to zero when no read is pending
	a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_rd |=> o_rdata == 8'h00) // RULE_02
		else $error("read data not idle");

	// control read returns the register
	a_rdata_ctl: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_rd && i_addr == cdac_pkg::ADDR_CONTROL
		|=> o_rdata == $past(control_q)) // RULE_14
		else $error("control read wrong");

	// high byte is stored whatever the mode
	a_high_store: assert property (@(posedge i_clk) disable iff (!i_nrst)
		wr_high |=> data_high_q == $past(i_wdata)) // RULE_12
		else $error("high byte not stored");

	// falling strobe in mode 101 gives a pulse
	a_fall_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		strobe_fall && src == cdac_pkg::CDAC_SRC_FALL
		|=> o_update_pulse) // RULE_11
		else $error("strobe fall pulse missing");

	// either edge counts in mode 110
	a_both_edges: assert property (@(posedge i_clk) disable iff (!i_nrst)
		src == cdac_pkg::CDAC_SRC_BOTH && (strobe_rise || strobe_fall)
		|-> update_now) // RULE_11
		else $error("edge missed in both mode");

	// rising edge mode ignores falls
	a_rise_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
		src == cdac_pkg::CDAC_SRC_RISE && strobe_fall |-> !update_now) // RULE_11
		else $error("fall accepted in rise mode");

	// timer 0 mode waits for its own overflow
	a_timer0_wait: assert property (@(posedge i_clk) disable iff (!i_nrst)
		src == cdac_pkg::CDAC_SRC_T0 && !i_timer_ovf[0] |-> !update_now) // RULE_10
		else $error("update without timer 0");

	// timer 1 mode waits for its own overflow
	a_timer1_wait: assert property (@(posedge i_clk) disable iff (!i_nrst)
		src == cdac_pkg::CDAC_SRC_T1 && !i_timer_ovf[1] |-> !update_now) // RULE_10
		else $error("update without timer 1");

	// scheduled updates copy the stored bytes
	a_held_copy: assert property (@(posedge i_clk) disable iff (!i_nrst)
		update_now && src != cdac_pkg::CDAC_SRC_WRITE
		|=> code_q == {$past(data_high_q), $past(data_low_q[7:6])}) // RULE_12
		else $error("held word not copied");

	// edges from the synchroniser are single-cycle
	a_edge_single: assert property (@(posedge i_clk) disable iff (!i_nrst)
		strobe_rise || strobe_fall |=> !strobe_rise && !strobe_fall) // RULE_17
		else $error("strobe edge too long");

	// every latch update is announced by the pulse
	a_pulse_on: assert property (@(posedge i_clk) disable iff (!i_nrst)
		update_now |=> o_update_pulse) // RULE_17
		else $error("update pulse missing");

	// and no pulse without an update
	a_pulse_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!update_now |=> !o_update_pulse) // RULE_17
		else $error("spurious update pulse");

	// disabled converter leaves the pin to the port
	a_disabled_gpio: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!control_q[cdac_pkg::CTL_ENABLE_BIT] |=> !o_pin_takeover) // RULE_02
		else $error("pin taken while disabled");
endmodule // cdac_ctrl

// ===== sim/test_current_dac_update_control.sv
// self-checking bench for the current dac update control block
module test_current_dac_update_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] LO = cdac_pkg::ADDR_DATA_LOW;
	localparam logic [7:0] HI = cdac_pkg::ADDR_DATA_HIGH;
	localparam logic [7:0] CT = cdac_pkg::ADDR_CONTROL;
	logic i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic i_convert_strobe = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, hb;
	logic [3:0] i_timer_ovf = 4'h0;
	logic [9:0] o_code, exp_code;
	logic [1:0] o_full_scale_select;
	logic o_converter_enable, o_bias_request, o_pin_takeover, o_update_pulse;
	logic s, hit;
	int bad_count = 0, checks_done = 0, pulses = 0, p0;

	cdac_ctrl uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_timer_ovf(i_timer_ovf), .i_convert_strobe(i_convert_strobe),
		.o_code(o_code), .o_full_scale_select(o_full_scale_select),
		.o_converter_enable(o_converter_enable),
		.o_bias_request(o_bias_request), .o_pin_takeover(o_pin_takeover),
		.o_update_pulse(o_update_pulse));

	// free-running 100 MHz clock
	initial begin
		forever #5 i_clk = ~i_clk;
	end

	// count update pulses to prove one pulse per qualifying edge
	always @(posedge i_clk) begin
		if (o_update_pulse === 1'b1) pulses++;
	end

	task automatic chk(input logic [9:0] seen, input logic [9:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
		end
	endtask

	// strobes launched on an edge and dropped on the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(10'(o_rdata), 10'(want));
	endtask

	task automatic tmr(input logic [3:0] m);
		@(posedge i_clk);
		i_timer_ovf <= m;
		@(posedge i_clk);
		i_timer_ovf <= 4'h0;
		#1;
	endtask

	// latch and pulse both launch on the taking edge; pulse lasts one cycle
	task automatic upd(input logic [9:0] c, input logic p);
		chk(o_code, c);
		chk(10'(o_update_pulse), 10'(p));
		@(posedge i_clk);
		#1;
		chk(10'(o_update_pulse), 10'h000);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// watchdog: the sequence needs a few thousand ns at most
	initial begin
		#50000;
		bad_count++;
		final_report;
	end

	initial begin
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		#1;
		chk(10'(o_full_scale_select), 10'h002);
		chk(10'({o_converter_enable, o_bias_request, o_pin_takeover}), 10'h0);
		rd(CT, 8'h72);
		rd(HI, 8'h00);
		// low byte is held until the high write latches it
		wr(LO, 8'h7F);
		chk(o_code, 10'h000);
		rd(LO, 8'h40);
		wr(HI, 8'hA5);
		upd(10'h295, 1'b1);
		rd(8'h00, 8'h00);
		wr(8'h98, 8'hFF);
		rd(HI, 8'hA5);
		// software would also set port0 skip mask bit one here; no pin
		wr(CT, 8'hFF);
		rd(CT, 8'hF3);
		chk(10'({o_converter_enable, o_bias_request, o_pin_takeover}), 10'h7);
		chk(10'(o_full_scale_select), 10'h3);
		// every full-scale code with the converter off
		for (int f = 0; f < 3; f++) begin
			wr(CT, {6'h1C, 2'(f)});
			@(posedge i_clk);
			#1;
			chk(10'(o_full_scale_select), 10'(f));
			chk(10'(o_pin_takeover), 10'h0);
		end
		exp_code = 10'h295;
		// timer modes: other timers ignored, own overflow copies word
		for (int n = 0; n < 4; n++) begin
			hb = 8'h30 + 8'(n);
			wr(CT, {1'b1, 3'(n), 4'h1});
			wr(LO, 8'h80);
			wr(HI, hb);
			chk(o_code, exp_code);
			tmr(~(4'h1 << n));
			chk(o_code, exp_code);
			tmr(4'h1 << n);
			exp_code = {hb, 2'b10};
			upd(exp_code, 1'b1);
		end
		// strobe modes: two opposite edges each, fresh data each time
		for (int m = 4; m < 7; m++) begin
			wr(CT, {1'b1, 3'(m), 4'h2});
			for (int k = 0; k < 2; k++) begin
				hb = hb + 8'h11;
				wr(HI, hb);
				s = ~i_convert_strobe;
				p0 = pulses;
				@(posedge i_clk);
				i_convert_strobe <= s;
				repeat (6) @(posedge i_clk);
				#1;
				hit = (m == 6) || ((m == 4) == s);
				if (hit) exp_code = {hb, 2'b10};
				chk(o_code, exp_code);
				chk(10'(pulses - p0), 10'(hit));
			end
		end
		final_report;
	end
endmodule // test_current_dac_update_control
